//--- verilog/tcmdec_top.sv
/*
  Address decoder for the instruction and data tightly coupled memories.
  Routes each fetch and data access to one memory or to the bus interface
  unit, holds the enable and write buffer control bits, and stalls the core
  for unbuffered writes, a full write buffer and drain requests.
  Assumes the core holds its request while stall is high, and that the
  memories and bus unit report their write buffer state on the same clock.
*/
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
// What this block does
// [R01] Lowest 64MB goes to instruction memory, next 64MB to data memory.
// [R02] Smaller memories alias through their window; upper bits ignored.
// [R03] Addresses above 128MB go to the bus interface unit.
// [R04] Instruction fetches in the data memory region always go to the bus.
// [R05] Data accesses reach both memories when each is enabled.
// [R06] A disabled memory's region is redirected to the bus.
// [R07] Boot pin at reset enables both memories if high, disables if low.
// [R08] Reset vector is 0xFFFF0000 when high-vectors pin high, else zero.
// [R09] After reset the bus write buffer is off; writes are unbuffered.
// [R10] Buffer on: address bit 28 high unbuffered, low buffered.
// [R11] A buffered write stalls while the bus write buffer is full.
// [R12] Enabled memory writes stay off the bus; disabled ones follow buffer.
// [R13] Size code 0 is absent, 1 is 1KB, doubling up to code 17 at 64MB.
// [R14] Configured memory sizes are readable by software.
// [R15] Control bit 12 set enables instruction memory.
// [R16] Control bit 12 clear sends its region accesses to the bus.
// [R17] Disabling a memory leaves its contents untouched.
// [R18] Control bit 2 set enables data memory.
// [R19] Control bit 2 clear sends data region accesses to the bus.
// [R20] Software drains the memory write buffers before disabling a memory.
// [R21] Software updates the control register by read-modify-write.
// [R22] Drain operation stalls until all write buffers are empty.
// [R23] Region code bits 31:26: zero instruction, one data, else bus.
module tcmdec_top
  import tcmdec_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic boot_mem_enable_pin,
  input wire logic high_vectors_pin,
  input wire logic [4:0] instr_mem_size_input,
  input wire logic [4:0] data_mem_size_input,
  input wire logic fetch_req,
  input wire logic [ADDR_W-1:0] fetch_addr,
  input wire logic data_req,
  input wire logic data_write,
  input wire logic [ADDR_W-1:0] core_data_address,
  input wire logic ahb_wbuf_full,
  input wire logic ahb_wbuf_empty,
  input wire logic ahb_write_done,
  input wire logic tcm_wbuf_empty,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic fetch_instr_sel,
  output logic fetch_ahb_sel,
  output logic [ADDR_W-1:0] fetch_mem_addr,
  output logic data_instr_sel,
  output logic data_data_sel,
  output logic data_ahb_sel,
  output logic data_ahb_buffered,
  output logic [ADDR_W-1:0] data_mem_addr,
  output logic core_stall,
  output logic [31:0] reset_vector
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [1:0] boot_sync_reg;
  logic [1:0] hivec_sync_reg;
  logic [4:0] isize_meta_reg;
  logic [4:0] isize_reg;
  logic [4:0] dsize_meta_reg;
  logic [4:0] dsize_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_sync_reg <= 2'h0;
    end else begin
      boot_sync_reg <= {boot_sync_reg[0], boot_mem_enable_pin};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hivec_sync_reg <= 2'h0;
    end else begin
      hivec_sync_reg <= {hivec_sync_reg[0], high_vectors_pin};
    end
  end

  // Size codes are static straps, so a bitwise two-stage copy is enough;
  // a code that moved at run time could be seen half old, half new
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      isize_meta_reg <= 5'h00;
      isize_reg <= 5'h00;
      dsize_meta_reg <= 5'h00;
      dsize_reg <= 5'h00;
    end else begin
      isize_meta_reg <= instr_mem_size_input;
      isize_reg <= isize_meta_reg;
      dsize_meta_reg <= data_mem_size_input;
      dsize_reg <= dsize_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Offset mask for a size code; codes beyond the top act as the full 64MB
  function automatic logic [ADDR_W-1:0] size_mask(input logic [4:0] code);
    logic [ADDR_W-1:0] m;
    m = '0;
    if (code == TCMDEC_SIZE_NONE) begin
      m = '0;
    end else if (code >= TCMDEC_SIZE_MAX) begin
      m = ADDR_W'((64'h1 << TCMDEC_REGION_LSB) - 64'h1);
    end else begin
      m = ADDR_W'((64'h1 << (TCMDEC_KB_SHIFT + int'(code) - 1)) - 64'h1);
    end
    return m; // [R02] [R13]
  endfunction

  function automatic tcmdec_target_t region(input logic [ADDR_W-1:0] a);
    logic [5:0] r;
    r = a[TCMDEC_REGION_MSB:TCMDEC_REGION_LSB];
    if (r == TCMDEC_REGION_INSTR) begin
      return TCMDEC_TGT_INSTR; // [R01] [R23]
    end else if (r == TCMDEC_REGION_DATA) begin
      return TCMDEC_TGT_DATA; // [R01] [R23]
    end else begin
      return TCMDEC_TGT_AHB; // [R03] [R23]
    end
  endfunction

  // Offset of an access inside a memory of the given size code
  function automatic logic [ADDR_W-1:0] alias_addr(
    input logic [ADDR_W-1:0] a,
    input logic [4:0] code
  );
    return a & size_mask(code); // [R02]
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Control register

  logic instr_en_reg;
  logic data_en_reg;
  logic wbuf_en_reg;
  logic boot_seen_reg;
  logic [1:0] boot_cnt_reg;
  logic boot_take;
  logic ctrl_wr;
  logic drain_wr;

  assign ctrl_wr = reg_write && (reg_addr == TCMDEC_CTRL_OFS);
  assign drain_wr = reg_write && (reg_addr == TCMDEC_DRAIN_OFS);

  // The strap reaches the second synchroniser stage on the second edge
  // after release, so it can only be trusted from the third edge on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_cnt_reg <= 2'h0;
    end else if (boot_cnt_reg != TCMDEC_BOOT_WAIT) begin
      boot_cnt_reg <= boot_cnt_reg + 2'h1;
    end
  end

  assign boot_take = !boot_seen_reg && (boot_cnt_reg == TCMDEC_BOOT_WAIT);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_seen_reg <= 1'b0;
    end else if (boot_take) begin
      boot_seen_reg <= 1'b1;
    end
  end

  // Boot strap is taken once the synchroniser has settled, never as a
  // reset value, so the async reset stays a constant. A control write
  // up to that edge loses its memory enable bits: the strap has the last word.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_en_reg <= 1'b0;
    end else if (boot_take) begin
      instr_en_reg <= boot_sync_reg[1]; // [R07]
    end else if (ctrl_wr && boot_seen_reg) begin
      instr_en_reg <= reg_wdata[TCMDEC_INSTR_EN_BIT]; // [R15] [R16] [R17]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_en_reg <= 1'b0;
    end else if (boot_take) begin
      data_en_reg <= boot_sync_reg[1]; // [R07]
    end else if (ctrl_wr && boot_seen_reg) begin
      data_en_reg <= reg_wdata[TCMDEC_DATA_EN_BIT]; // [R18] [R19] [R17]
    end
  end

  // Only the write buffer enable keeps its reset value until software writes it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wbuf_en_reg <= TCMDEC_WBUF_EN_RST; // [R09]
    end else if (ctrl_wr) begin
      wbuf_en_reg <= reg_wdata[TCMDEC_WBUF_EN_BIT]; // [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Routing

  tcmdec_target_t f_tgt;
  tcmdec_target_t d_tgt;
  logic d_to_ahb;
  logic d_buffered;

  always_comb begin
    f_tgt = region(fetch_addr);
    if (f_tgt == TCMDEC_TGT_DATA) begin
      f_tgt = TCMDEC_TGT_AHB; // [R04]
    end else if (f_tgt == TCMDEC_TGT_INSTR && !instr_en_reg) begin
      f_tgt = TCMDEC_TGT_AHB; // [R06] [R16]
    end
    d_tgt = region(core_data_address);
    if (d_tgt == TCMDEC_TGT_INSTR && !instr_en_reg) begin
      d_tgt = TCMDEC_TGT_AHB; // [R06] [R16]
    end else if (d_tgt == TCMDEC_TGT_DATA && !data_en_reg) begin
      d_tgt = TCMDEC_TGT_AHB; // [R06] [R19]
    end
    d_to_ahb = data_req && (d_tgt == TCMDEC_TGT_AHB); // [R05] [R12]
    d_buffered = d_to_ahb && data_write && wbuf_en_reg
      && !core_data_address[TCMDEC_UNBUF_BIT]; // [R10] [R12]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_instr_sel <= 1'b0;
      fetch_ahb_sel <= 1'b0;
      fetch_mem_addr <= '0;
    end else begin
      fetch_instr_sel <= fetch_req && f_tgt == TCMDEC_TGT_INSTR;
      fetch_ahb_sel <= fetch_req && f_tgt == TCMDEC_TGT_AHB;
      if (f_tgt == TCMDEC_TGT_INSTR) begin
        fetch_mem_addr <= alias_addr(fetch_addr, isize_reg); // [R02]
      end else begin
        fetch_mem_addr <= fetch_addr;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_instr_sel <= 1'b0;
      data_data_sel <= 1'b0;
      data_ahb_sel <= 1'b0;
      data_ahb_buffered <= 1'b0;
      data_mem_addr <= '0;
    end else begin
      data_instr_sel <= data_req && d_tgt == TCMDEC_TGT_INSTR; // [R05]
      data_data_sel <= data_req && d_tgt == TCMDEC_TGT_DATA; // [R05]
      data_ahb_sel <= d_to_ahb;
      data_ahb_buffered <= d_buffered;
      if (d_tgt == TCMDEC_TGT_INSTR) begin
        data_mem_addr <= alias_addr(core_data_address, isize_reg); // [R02]
      end else if (d_tgt == TCMDEC_TGT_DATA) begin
        data_mem_addr <= alias_addr(core_data_address, dsize_reg); // [R02]
      end else begin
        data_mem_addr <= core_data_address;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stall control

  logic unbuf_wait_reg;
  logic drain_reg;
  logic stall_next;
  logic unbuf_start;

  // Unbuffered bus write: the core waits for the bus unit to finish it
  assign unbuf_start = d_to_ahb && data_write && !d_buffered;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unbuf_wait_reg <= 1'b0;
    end else if (unbuf_wait_reg) begin
      unbuf_wait_reg <= !ahb_write_done; // [R09]
    end else begin
      unbuf_wait_reg <= unbuf_start; // [R09] [R12]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drain_reg <= 1'b0;
    end else if (drain_wr) begin
      drain_reg <= 1'b1; // [R22]
    end else if (ahb_wbuf_empty && tcm_wbuf_empty) begin
      drain_reg <= 1'b0; // [R22]
    end
  end

  always_comb begin
    stall_next = unbuf_wait_reg && !ahb_write_done; // [R09]
    // Stall in the cycle after the request itself, not one later, or the
    // core would run ahead of a write that has not reached the bus
    if (!unbuf_wait_reg && unbuf_start) begin
      stall_next = 1'b1; // [R09] [R12]
    end
    if (d_buffered && ahb_wbuf_full) begin
      stall_next = 1'b1; // [R11]
    end
    if (drain_reg && !(ahb_wbuf_empty && tcm_wbuf_empty)) begin
      stall_next = 1'b1; // [R22]
    end
    if (drain_wr) begin
      stall_next = 1'b1; // [R22]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_stall <= 1'b0;
    end else begin
      core_stall <= stall_next;
    end
  end

  // Follows the synchronised pin, so a cold boot can move the first fetch
  // out of an uninitialised memory
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_vector <= TCMDEC_VEC_LOW;
    end else begin
      reset_vector <= hivec_sync_reg[1] ? TCMDEC_VEC_HIGH
        : TCMDEC_VEC_LOW; // [R08]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read port
  // Read data stand one cycle only and idle at zero, so a stale word
  // can never pass for the answer to a later read

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      reg_rdata <= 32'h0000_0000;
      if (reg_addr == TCMDEC_CTRL_OFS) begin
        reg_rdata[TCMDEC_INSTR_EN_BIT] <= instr_en_reg;
        reg_rdata[TCMDEC_DATA_EN_BIT] <= data_en_reg;
        reg_rdata[TCMDEC_WBUF_EN_BIT] <= wbuf_en_reg;
      end else if (reg_addr == TCMDEC_SIZE_OFS) begin
        reg_rdata[TCMDEC_ISIZE_LSB +: 5] <= isize_reg; // [R14]
        reg_rdata[TCMDEC_DSIZE_LSB +: 5] <= dsize_reg; // [R14]
      end else if (reg_addr == TCMDEC_VECTOR_OFS) begin
        reg_rdata <= reset_vector;
      end else if (reg_addr == TCMDEC_STATUS_OFS) begin
        reg_rdata[0] <= drain_reg;
        reg_rdata[1] <= unbuf_wait_reg;
        reg_rdata[2] <= core_stall;
      end
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule // tcmdec_top

//--- verilog/tcmdec_pkg.sv
/*
  Package for the tightly coupled memory address decoder: region codes,
  register offsets, control bit positions, reset values and size codes.
  Assumes a 32-bit core address space and a 32-bit software register port.
*/
package tcmdec_pkg;

  // Region decode on address bits 31 to 26
  localparam int TCMDEC_REGION_MSB = 31;
  localparam int TCMDEC_REGION_LSB = 26;
  localparam logic [5:0] TCMDEC_REGION_INSTR = 6'h00;
  localparam logic [5:0] TCMDEC_REGION_DATA = 6'h01;

  // Write buffer select address bit
  localparam int TCMDEC_UNBUF_BIT = 28;

  // Register offsets (byte addresses)
  localparam logic [7:0] TCMDEC_CTRL_OFS = 8'h00;
  localparam logic [7:0] TCMDEC_SIZE_OFS = 8'h04;
  localparam logic [7:0] TCMDEC_VECTOR_OFS = 8'h08;
  localparam logic [7:0] TCMDEC_DRAIN_OFS = 8'h0C;
  localparam logic [7:0] TCMDEC_STATUS_OFS = 8'h10;

  // Control register bit positions
  localparam int TCMDEC_DATA_EN_BIT = 2;
  localparam int TCMDEC_WBUF_EN_BIT = 3;
  localparam int TCMDEC_INSTR_EN_BIT = 12;

  // Size register field positions
  localparam int TCMDEC_DSIZE_LSB = 6;
  localparam int TCMDEC_ISIZE_LSB = 18;

  // Reset values
  localparam logic TCMDEC_WBUF_EN_RST = 1'b0;
  // Edges after reset release before the boot strap is trusted
  localparam logic [1:0] TCMDEC_BOOT_WAIT = 2'h2;

  // Reset vectors
  localparam logic [31:0] TCMDEC_VEC_LOW = 32'h0000_0000;
  localparam logic [31:0] TCMDEC_VEC_HIGH = 32'hFFFF_0000;

  // Size codes
  localparam logic [4:0] TCMDEC_SIZE_NONE = 5'h00;
  localparam logic [4:0] TCMDEC_SIZE_MAX = 5'h11;
  localparam int TCMDEC_KB_SHIFT = 10;

  typedef enum logic [1:0] {
    TCMDEC_TGT_INSTR,
    TCMDEC_TGT_DATA,
    TCMDEC_TGT_AHB
  } tcmdec_target_t;

endpackage

//--- verification/tcmdec_bus_model.sv
/*
  Bus interface unit model: finishes each unbuffered bus write after a
  delay set by the bench, from prompt to slow.
  Assumes the decoder's registered select and buffered outputs.
*/
`timescale 1ns/100ps
module tcmdec_bus_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_req,
  input wire logic ahb_sel,
  input wire logic buffered,
  input wire logic [3:0] delay,
  output logic ahb_write_done
);
  logic wr_reg;
  logic [3:0] cnt_reg;
  ////////////////////////////////////////
  // Completion only for writes the core must wait on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= 1'b0;
      cnt_reg <= 4'h0;
      ahb_write_done <= 1'b0;
    end else begin
      wr_reg <= wr_req;
      ahb_write_done <= (cnt_reg == 4'h1);
      if (ahb_sel && !buffered && wr_reg) begin
        cnt_reg <= delay;
      end else if (cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule // tcmdec_bus_model

//--- verification/tcmdec_checker.sv
/*
  Port assertions for the decoder: routing, aliasing, vectors, drain and
  register reads. Assumes size inputs are static around accesses.
*/
`timescale 1ns/100ps
module tcmdec_checker
  import tcmdec_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic high_vectors_pin,
  input wire logic [4:0] instr_mem_size_input,
  input wire logic [4:0] data_mem_size_input,
  input wire logic fetch_req,
  input wire logic [ADDR_W-1:0] fetch_addr,
  input wire logic data_req,
  input wire logic [ADDR_W-1:0] core_data_address,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic fetch_instr_sel,
  input wire logic fetch_ahb_sel,
  input wire logic [ADDR_W-1:0] fetch_mem_addr,
  input wire logic data_instr_sel,
  input wire logic data_data_sel,
  input wire logic data_ahb_sel,
  input wire logic [ADDR_W-1:0] data_mem_addr,
  input wire logic core_stall,
  input wire logic [31:0] reset_vector
);
  function automatic logic [31:0] msk(logic [4:0] c);
    return (c == 5'h00) ? 32'h0 : (32'h400 << (c - 5'h01)) - 32'h1;
  endfunction
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  a_fetch_data_bus: assert property (
    fetch_req && fetch_addr[31:26] == 6'h01
    |=> fetch_ahb_sel && !fetch_instr_sel) else $error("fetch not on bus");
  a_high_bus: assert property (
    data_req && core_data_address[31:27] != 5'h00
    |=> data_ahb_sel && !data_data_sel && !data_instr_sel)
    else $error("high data access not on bus");
  a_one_target: assert property (
    data_req |=> $onehot({data_instr_sel, data_data_sel, data_ahb_sel}))
    else $error("data access target not unique");
  a_fetch_alias: assert property (
    fetch_instr_sel |-> fetch_mem_addr ==
    ($past(fetch_addr) & msk(instr_mem_size_input)))
    else $error("fetch address not aliased");
  a_data_alias: assert property (
    data_data_sel |-> data_mem_addr ==
    ($past(core_data_address) & msk(data_mem_size_input)))
    else $error("data address not aliased");
  a_vec_high: assert property (
    high_vectors_pin [*5] |-> reset_vector == TCMDEC_VEC_HIGH)
    else $error("high vector wrong");
  a_vec_low: assert property (
    !high_vectors_pin [*5] |-> reset_vector == TCMDEC_VEC_LOW)
    else $error("low vector wrong");
  a_drain_stall: assert property (
    reg_write && reg_addr == TCMDEC_DRAIN_OFS |=> core_stall)
    else $error("drain did not stall");
  a_rdata_idle: assert property (
    !reg_read |=> reg_rdata == 32'h0) else $error("read data not idle");
  a_size_read: assert property (
    reg_read && reg_addr == TCMDEC_SIZE_OFS |=> reg_rdata == {9'h0,
    $past(instr_mem_size_input), 7'h0, $past(data_mem_size_input), 6'h0})
    else $error("size read wrong");
endmodule // tcmdec_checker

bind tcmdec_top tcmdec_checker #(.ADDR_W(ADDR_W)) tcmdec_checker_inst (
  .clk, .rst_n, .high_vectors_pin, .instr_mem_size_input,
  .data_mem_size_input, .fetch_req, .fetch_addr, .data_req,
  .core_data_address, .reg_addr, .reg_write, .reg_read, .reg_rdata,
  .fetch_instr_sel, .fetch_ahb_sel, .fetch_mem_addr, .data_instr_sel,
  .data_data_sel, .data_ahb_sel, .data_mem_addr, .core_stall,
  .reset_vector);

//--- verification/tcmdec_tb.sv
/*
  Bench for the decoder: random accesses against an enable model,
  register reads, stalls, drain and vectors across four resets.
  Assumes the bus model completes unbuffered bus writes.
*/
`timescale 1ns/100ps
module tb
  import tcmdec_pkg::*;
;
  logic clk, rst_n, boot_mem_enable_pin, high_vectors_pin;
  logic [4:0] instr_mem_size_input, data_mem_size_input;
  logic fetch_req, data_req, data_write, ahb_wbuf_full, ahb_wbuf_empty;
  logic ahb_write_done, tcm_wbuf_empty, reg_write, reg_read;
  logic [31:0] fetch_addr, core_data_address, reg_wdata, reg_rdata;
  logic [31:0] fetch_mem_addr, data_mem_addr, reset_vector, seed, rv, ra;
  logic [7:0] reg_addr;
  logic fetch_instr_sel, fetch_ahb_sel, data_instr_sel, data_data_sel;
  logic data_ahb_sel, data_ahb_buffered, core_stall;
  logic [3:0] delay;
  int errors, num_checks;
  bit ien, den, wben;
  tcmdec_top tcmdec_top_inst (.clk, .rst_n, .boot_mem_enable_pin,
    .high_vectors_pin, .instr_mem_size_input, .data_mem_size_input,
    .fetch_req, .fetch_addr, .data_req, .data_write, .core_data_address,
    .ahb_wbuf_full, .ahb_wbuf_empty, .ahb_write_done, .tcm_wbuf_empty,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .fetch_instr_sel, .fetch_ahb_sel, .fetch_mem_addr, .data_instr_sel,
    .data_data_sel, .data_ahb_sel, .data_ahb_buffered, .data_mem_addr,
    .core_stall, .reset_vector);
  tcmdec_bus_model tcmdec_bus_model_inst (.clk, .rst_n,
    .wr_req(data_req & data_write), .ahb_sel(data_ahb_sel),
    .buffered(data_ahb_buffered), .delay, .ahb_write_done);
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] msk(logic [4:0] c);
    return (c == 5'h00) ? 32'h0 : (32'h400 << (c - 5'h01)) - 32'h1;
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    chk("rdata", e, reg_rdata);
  endtask
  // Bounded so a stuck stall ends as a mismatch, not a hang
  task automatic idle_wait();
    int n;
    n = 0;
    while (core_stall !== 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("stall_end", 32'h0, core_stall);
  endtask
  task automatic ctl(bit i, bit d, bit b);
    wr(TCMDEC_DRAIN_OFS, 32'h0);
    @(negedge clk);
    idle_wait();
    wr(TCMDEC_CTRL_OFS, {19'h0, i, 8'h0, b, d, 2'h0});
    {ien, den, wben} = {i, d, b};
    rd(TCMDEC_CTRL_OFS, {19'h0, i, 8'h0, b, d, 2'h0});
  endtask
  task automatic acc(bit f, bit w, logic [31:0] a, bit full);
    int t;
    bit bf;
    t = (a[31:26] == 6'h00 && ien) ? 0 :
        (a[31:26] == 6'h01 && den && !f) ? 1 : 2;
    bf = !f && w && t == 2 && wben && !a[28];
    @(posedge clk);
    fetch_req <= f;
    data_req <= !f;
    data_write <= w;
    fetch_addr <= a;
    core_data_address <= a;
    ahb_wbuf_full <= full;
    @(posedge clk);
    fetch_req <= 1'b0;
    data_req <= 1'b0;
    @(negedge clk);
    if (f) chk("fsel", 32'h1 << t, {fetch_ahb_sel, 1'b0, fetch_instr_sel});
    else chk("dsel", 32'h1 << t, {data_ahb_sel, data_data_sel, data_instr_sel});
    if (t < 2) chk("maddr", a & msk(t ? data_mem_size_input :
      instr_mem_size_input), f ? fetch_mem_addr : data_mem_addr);
    chk("buffered", bf, data_ahb_buffered);
    chk("stall", !f && w && t == 2 && (!bf || full), core_stall);
    @(posedge clk);
    ahb_wbuf_full <= 1'b0;
    idle_wait();
  endtask
  task automatic do_reset(bit boot, bit hv);
    rst_n <= 1'b0;
    boot_mem_enable_pin <= boot;
    high_vectors_pin <= hv;
    instr_mem_size_input <= 5'(rnd() % 18);
    data_mem_size_input <= 5'(rnd() % 18);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    {ien, den, wben} = {boot, boot, 1'b0};
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #800000;
    errors++;
    print_verdict();
  end
  initial begin
    {rst_n, fetch_req, data_req, data_write, reg_write, reg_read} = '0;
    {ahb_wbuf_full, boot_mem_enable_pin, high_vectors_pin} = '0;
    {ahb_wbuf_empty, tcm_wbuf_empty} = 2'h3;
    {fetch_addr, core_data_address, reg_wdata, reg_addr} = '0;
    {instr_mem_size_input, data_mem_size_input, delay} = '0;
    seed = 32'h6D29;
    for (int r = 0; r < 4; r++) begin
      do_reset(r[0], r[1]);
      rv = r[1] ? TCMDEC_VEC_HIGH : TCMDEC_VEC_LOW;
      chk("vector", rv, reset_vector);
      rd(TCMDEC_VECTOR_OFS, rv);
      rd(TCMDEC_SIZE_OFS, {9'h0, instr_mem_size_input, 7'h0,
        data_mem_size_input, 6'h0});
      rd(8'h14, 32'h0);
      for (int k = 0; k < 60; k++) begin
        rv = rnd();
        ra = rnd();
        if (k % 12 == 11) ctl(rv[4], rv[5], rv[6]);
        if (rv[3:2] != 2'h3) ra[31:26] = {5'h0, rv[2]};
        delay <= {1'b0, rv[9:7]} + 4'h1;
        acc(rv[0], rv[1], ra, rv[10]);
      end
      {ahb_wbuf_empty, tcm_wbuf_empty} <= {r[0], !r[0]};
      wr(TCMDEC_DRAIN_OFS, 32'h0);
      repeat (3) begin
        @(negedge clk);
        chk("drain", 32'h1, core_stall);
      end
      rd(TCMDEC_STATUS_OFS, 32'h5);
      {ahb_wbuf_empty, tcm_wbuf_empty} <= 2'h3;
      idle_wait();
    end
    print_verdict();
  end
endmodule // tb
